// ### rtl/wdg_pkg.sv
// Purpose: Shared constants and types for the watchdog timer core
// Assumes: 25 MHz system clock, APB register access
// Notes: All offsets, the period reset value and field positions other than status live here
package wdg_pkg;
   // Clock figures
   localparam int unsigned CLK_HZ = 25_000_000; // System clock
   localparam int unsigned SLOW_OSC_HZ = 31_000; // Slow oscillator rate
   // Cycles per slow tick, rounded down
   localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
   localparam logic [9:0] SLOW_DIV_LAST = 10'(SLOW_DIV - 1);
   // Counter and prescale figures
   localparam int unsigned CNT_W = 23; // Enough for 2^23 ticks
   localparam logic [4:0] MIN_SHIFT = 5'h05; // 1:32
   localparam logic [4:0] PSEL_MAX = 5'h12; // Highest legal code
   localparam logic [4:0] PSEL_RST = 5'h0B; // 1:65536 after reset
   // Enable mode codes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SOFT = 2'h1;
   localparam logic [1:0] MODE_AWAKE = 2'h2;
   localparam logic [1:0] MODE_ON = 2'h3;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00; // watchdog_control
   localparam logic [7:0] ADDR_PWR = 8'h04; // power_ctrl_status
   localparam logic [7:0] ADDR_STAT = 8'h08; // Flags and run state
   localparam logic [7:0] ADDR_COUNT = 8'h0C; // Live count
   localparam logic [7:0] ADDR_IRQ_STS = 8'h10; // Sticky events
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h14; // Write 1 to clear
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18; // Event enables
   // Field positions
   localparam int unsigned CTRL_SOFT_BIT = 0;
   localparam int unsigned CTRL_PSEL_LSB = 1;
   localparam int unsigned PWR_WDRST_BIT = 4;
   localparam int unsigned IRQ_TIMEOUT = 0;
   localparam int unsigned IRQ_WAKE = 1;
   localparam int unsigned IRQ_RESET = 2;
   localparam int unsigned IRQ_W = 3;
   // Count value at which a given shift expires
   function automatic logic [CNT_W-1:0] wdg_mask(input logic [4:0] sh);
      logic [CNT_W:0] one;
      one = 24'h000001 << sh;
      return 23'(one - 24'h000001);
   endfunction
   // Top level state
   typedef struct packed {
      logic [4:0] period;
      logic soft_on;
      logic wdrst;
      logic to_flag;
      logic pwrdn_flag;
      logic [IRQ_W-1:0] irq_sts;
      logic [IRQ_W-1:0] irq_en;
      logic sleep_d;
      logic ready;
      logic [31:0] rdata;
      logic slverr;
      logic reset_req;
      logic wake_req;
      logic irq;
   } wdg_state_t;
endpackage

// ### rtl/wdg_cnt_if.sv
// Purpose: Carrier between watchdog control, divider and counter
// Assumes: Single clock domain
// Notes: Tick is a one-cycle enable at the slow oscillator rate
`timescale 1ns/1ps
interface wdg_cnt_if;
   logic tick; // Slow oscillator enable
   logic clr; // Hold count at zero
   logic [4:0] shift; // Prescale exponent
   logic expire; // One-cycle time-out pulse
   logic [22:0] count; // Live count
   modport div (output tick);
   modport cnt (input tick, input clr, input shift,
                output expire, output count);
   modport ctl (input tick, input expire, input count,
                output clr, output shift);
endinterface

// ### rtl/wdg_osc_div.sv
// Purpose: Slow oscillator time base as an enable pulse
// Assumes: clk at 25 MHz
// Notes: Rate is nominal; real part tolerance is not modelled
`timescale 1ns/1ps
module wdg_osc_div
   import wdg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   wdg_cnt_if.div cif
);
   // Divider state
   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } wdg_div_t;
   wdg_div_t st_r;
   wdg_div_t st_nxt;
   // Free running count, tick on wrap
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == SLOW_DIV_LAST) begin
         st_nxt.cnt = 10'h000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 10'h001;
      end
   end
   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign cif.tick = st_r.tick;
   AST_TICK_GAP: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.tick |=> (!st_r.tick) [*8])
      else $error("slow tick came too soon");
endmodule

// ### rtl/wdg_counter.sv
// Purpose: Watchdog tick counter with time-out detect
// Assumes: Tick and clear come from the same clock domain
// Notes: Count restarts from zero after each time-out
`timescale 1ns/1ps
module wdg_counter
   import wdg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   wdg_cnt_if.cnt cif
);
   // Counter state
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic expire;
   } wdg_ctr_t;
   wdg_ctr_t st_r;
   wdg_ctr_t st_nxt;
   logic [CNT_W-1:0] lim; // Last count before time-out
   assign lim = wdg_mask(cif.shift);
   // Clear dominates; count only on slow ticks
   always_comb begin
      st_nxt = st_r;
      st_nxt.expire = 1'b0;
      if (cif.clr) begin
         st_nxt.cnt = '0;
      end else if (cif.tick) begin
         if (st_r.cnt >= lim) begin
            st_nxt.cnt = '0;
            st_nxt.expire = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 23'h000001;
         end
      end
   end
   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign cif.expire = st_r.expire;
   assign cif.count = st_r.cnt;
   AST_EXPIRE_CAUSE: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.expire |-> $past(cif.tick) && !$past(cif.clr))
      else $error("time-out without a slow tick");
endmodule

// ### rtl/wdg_top.sv
// Purpose: Watchdog timer core with APB registers and event interrupt
// Assumes: All inputs synchronous to clk; APB master keeps protocol
// Notes: Time-out asleep wakes the device, awake it requests a reset
//
// Behaviour
// - Counts slow oscillator ticks only, about 32 us base
// - Mode 11 runs always, also asleep
// - Mode 10 runs awake, stops asleep
// - Mode 01 follows the software enable bit
// - Mode 1x ignores the software enable bit
// - Mode 00 keeps the watchdog off
// - Period code sets prescale 2^(code+5)
// - Codes above 10010 act as 1:32
// - Reset loads period 01011, software enable 0
// - Count clears on kick, sleep, fail, off, startup
// - Sleep entry and exit both clear count
// - Held clear until oscillator startup timer ends
// - Oscillator divider changes leave watchdog alone
// - Time-out asleep wakes device and sets flags
// - Reset flag sits at power status bit 4
// - Control bits 7-6 read zero, enable bit 0
// - Missed kick while awake forces a reset
`timescale 1ns/1ps
module wdg_top
   import wdg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] cfg_watchdog_mode,
   input wire logic kick_instruction,
   input wire logic sleep_active,
   input wire logic osc_fail,
   input wire logic osc_startup_timer,
   output logic wd_reset_req,
   output logic wd_wake_req,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic wd_reset_flag,
   output logic irq
);
   import wdg_pkg::*;

   wdg_state_t st_r; // Registered state
   wdg_state_t st_nxt; // Next state
   wdg_cnt_if cif(); // Link to divider and counter
   logic run; // Watchdog active now
   logic sleep_edge; // Sleep entered or left
   logic wr_commit; // Write takes effect
   logic ask; // Access phase waiting for answer

   // Slow time base
   wdg_osc_div u_div (
      .clk(clk),
      .rst_b(rst_b),
      .cif(cif.div)
   );

   // Tick counter
   wdg_counter u_cnt (
      .clk(clk),
      .rst_b(rst_b),
      .cif(cif.cnt)
   );

   // Mode decode; software bit only matters in mode 01
   // The mode field is strapped; a change mid-run only
   // clears or starts the count, it never times out by itself.
   always_comb begin
      case (cfg_watchdog_mode)
         MODE_ON: run = 1'b1;
         MODE_AWAKE: run = !sleep_active;
         MODE_SOFT: run = st_r.soft_on;
         MODE_OFF: run = 1'b0;
         default: run = 1'b0;
      endcase
   end

   // Both directions of a sleep change clear the count
   assign sleep_edge = sleep_active ^ st_r.sleep_d;

   // Clear sources; startup timer holds it at zero while it runs.
   // The oscillator divider select is not an input at all, so a
   // change there cannot disturb the count.
   assign cif.clr = kick_instruction | sleep_edge | osc_fail
      | !run | osc_startup_timer;

   // Reserved codes fall back to the shortest interval
   assign cif.shift = (st_r.period > PSEL_MAX) ? MIN_SHIFT
      : st_r.period + MIN_SHIFT;

   // APB handshake: answer one cycle into the access phase
   // One fixed wait state keeps the read mux off the pready
   // path, at the cost of one extra cycle per transfer.
   assign ask = psel && penable && !st_r.ready;
   assign wr_commit = psel && penable && st_r.ready && pwrite;

   // Next state
   always_comb begin
      logic [IRQ_W-1:0] ev;
      logic [31:0] rd;
      logic hit;
      ev = '0;
      rd = 32'h00000000;
      hit = 1'b1;
      st_nxt = st_r;
      st_nxt.sleep_d = sleep_active;
      st_nxt.reset_req = 1'b0;
      st_nxt.wake_req = 1'b0;
      st_nxt.ready = 1'b0;
      st_nxt.slverr = 1'b0;
      // Read mux; unused upper bits stay zero
      case (paddr)
         ADDR_CTRL: begin
            rd[CTRL_SOFT_BIT] = st_r.soft_on;
            rd[CTRL_PSEL_LSB +: 5] = st_r.period;
         end
         ADDR_PWR: rd[PWR_WDRST_BIT] = st_r.wdrst;
         ADDR_STAT: rd[2:0] = {run, st_r.pwrdn_flag, st_r.to_flag};
         ADDR_COUNT: rd[CNT_W-1:0] = cif.count;
         ADDR_IRQ_STS: rd[IRQ_W-1:0] = st_r.irq_sts;
         ADDR_IRQ_CLR: rd = 32'h00000000; // Write only
         ADDR_IRQ_EN: rd[IRQ_W-1:0] = st_r.irq_en;
         default: hit = 1'b0; // Unmapped
      endcase
      // Answer the access phase
      if (ask) begin
         st_nxt.ready = 1'b1;
         st_nxt.rdata = pwrite ? 32'h00000000 : rd;
         st_nxt.slverr = !hit;
      end
      // Register writes at the completing edge
      if (wr_commit) begin
         case (paddr)
            ADDR_CTRL: begin
               st_nxt.period = pwdata[CTRL_PSEL_LSB +: 5];
               st_nxt.soft_on = pwdata[CTRL_SOFT_BIT];
            end
            ADDR_PWR: begin
               // Write 1 clears the reset flag
               if (pwdata[PWR_WDRST_BIT]) begin
                  st_nxt.wdrst = 1'b0;
               end
            end
            ADDR_IRQ_CLR: begin
               st_nxt.irq_sts = st_r.irq_sts & ~pwdata[IRQ_W-1:0];
            end
            ADDR_IRQ_EN: st_nxt.irq_en = pwdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
      // Kick marks a clean run: both flags drop
      if (kick_instruction) begin
         st_nxt.to_flag = 1'b0;
         st_nxt.pwrdn_flag = 1'b0;
      end
      // Sleep entry records power-down; the count clear
      // itself rides on cif.clr, not on this flag
      if (sleep_active && !st_r.sleep_d) begin
         st_nxt.pwrdn_flag = 1'b1;
      end
      // Time-out handling; sets win over any clear above
      if (cif.expire) begin
         ev[IRQ_TIMEOUT] = 1'b1;
         st_nxt.to_flag = 1'b1;
         if (sleep_active) begin
            // Asleep: wake instead of reset
            st_nxt.wake_req = 1'b1;
            st_nxt.pwrdn_flag = 1'b1;
            ev[IRQ_WAKE] = 1'b1;
         end else begin
            // Awake: the kick never came
            st_nxt.reset_req = 1'b1;
            st_nxt.wdrst = 1'b1;
            st_nxt.period = PSEL_RST;
            st_nxt.soft_on = 1'b0;
            ev[IRQ_RESET] = 1'b1;
         end
      end
      // Sticky events and the level interrupt
      st_nxt.irq_sts = st_nxt.irq_sts | ev;
      st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_en);
   end

   // State register; reset values are constants only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.period <= PSEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.slverr;
   assign wd_reset_req = st_r.reset_req;
   assign wd_wake_req = st_r.wake_req;
   assign timeout_flag = st_r.to_flag;
   assign powerdown_flag = st_r.pwrdn_flag;
   assign wd_reset_flag = st_r.wdrst;
   assign irq = st_r.irq;

   // Checks on the whole block
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // No kick, fail, startup timer or sleep change either way (run is not included), a tick due and no wrap at this tick.
   // A plain signal, so it may join boolean terms.
   logic quiet; // Count must step by one next cycle if run is high
   assign quiet = !kick_instruction && !osc_fail && !osc_startup_timer
      && !sleep_edge && cif.tick
      && cif.count < wdg_mask(cif.shift);

   AST_MODE_ON: assert property (
      cfg_watchdog_mode == MODE_ON && sleep_active && quiet
      |=> cif.count == $past(cif.count) + 23'h000001)
      else $error("mode 11 did not count asleep");
   AST_AWAKE_SLEEP: assert property (
      cfg_watchdog_mode == MODE_AWAKE && sleep_active
      |=> cif.count == 23'h000000)
      else $error("mode 10 counted asleep");
   AST_SOFT_OFF: assert property (
      cfg_watchdog_mode == MODE_SOFT && !st_r.soft_on
      |=> cif.count == 23'h000000)
      else $error("mode 01 counted with enable low");
   AST_SOFT_IGNORED: assert property (
      cfg_watchdog_mode == MODE_AWAKE && !sleep_active
      && !st_r.soft_on && quiet
      |=> cif.count != 23'h000000)
      else $error("mode 10 stopped by enable bit");
   AST_MODE_OFF: assert property (
      cfg_watchdog_mode == MODE_OFF |=> cif.count == 23'h000000)
      else $error("mode 00 counted");
   AST_PRESCALE: assert property (
      st_r.period <= PSEL_MAX |-> cif.shift == st_r.period + 5'h05)
      else $error("wrong prescale exponent");
   AST_RESERVED: assert property (
      st_r.period > PSEL_MAX |-> cif.shift == 5'h05)
      else $error("reserved code not at 1:32");
   AST_RELOAD: assert property (
      st_r.reset_req |-> st_r.period == 5'h0B && !st_r.soft_on)
      else $error("control not reloaded on reset");
   AST_KICK: assert property (
      kick_instruction |=> cif.count == 23'h000000)
      else $error("kick did not clear count");
   AST_SLEEP_EDGE: assert property (
      $changed(sleep_active) |=> cif.count == 23'h000000)
      else $error("sleep change did not clear count");
   AST_OST_HOLD: assert property (
      osc_startup_timer [*2] |=> cif.count == 23'h000000)
      else $error("count moved during startup timer");
   AST_WAKE: assert property (
      cif.expire && sleep_active
      |=> wd_wake_req && !wd_reset_req && timeout_flag ##1 !wd_wake_req)
      else $error("asleep time-out did not wake");
   AST_RESET: assert property (
      cif.expire && !sleep_active
      |=> wd_reset_req && wd_reset_flag && !wd_wake_req)
      else $error("awake time-out did not reset");
   AST_RD_ZERO: assert property (
      ask && !pwrite && paddr == ADDR_CTRL
      |=> pready && prdata[31:6] == 26'h0000000)
      else $error("control upper bits not zero");
   AST_IRQ: assert property (
      st_r.irq_sts[IRQ_RESET] && st_r.irq_en[IRQ_RESET] |-> irq)
      else $error("enabled event gave no interrupt");

   COV_RESET: cover property (cif.expire && !sleep_active);
   COV_WAKE: cover property (cif.expire && sleep_active);
   COV_RESERVED: cover property (st_r.period > PSEL_MAX && cif.expire);
   COV_IRQ_CLR: cover property (irq ##[1:20] !irq);
   COV_SLEEP_RUN: cover property (
      cfg_watchdog_mode == MODE_ON && sleep_active && cif.tick);

   // Bus answer shape: pulses of one cycle, error only with
   // ready; writes land at the completing edge
   AST_READY_PULSE: assert property (
      pready |=> !pready)
      else $error("pready stood longer than one cycle");
   AST_ERR_READY: assert property (
      pslverr |-> pready)
      else $error("slave error without ready");
   AST_CTRL_WRITE: assert property (
      wr_commit && paddr == ADDR_CTRL && !cif.expire
      |=> st_r.period == $past(pwdata[CTRL_PSEL_LSB +: 5])
      && st_r.soft_on == $past(pwdata[CTRL_SOFT_BIT]))
      else $error("control write did not land");
   AST_PWR_CLEAR: assert property (
      wr_commit && paddr == ADDR_PWR && pwdata[PWR_WDRST_BIT]
      && !cif.expire |=> !wd_reset_flag)
      else $error("reset flag not cleared by write");
   AST_UNMAPPED: assert property (
      ask && paddr > ADDR_IRQ_EN |=> pslverr)
      else $error("unmapped access gave no error");

   // Clear sources and disabled modes keep the count idle,
   // so no request can follow two cycles later
   AST_FAIL_CLEAR: assert property (
      osc_fail |=> cif.count == 23'h000000)
      else $error("oscillator failure did not clear count");
   AST_OFF_QUIET: assert property (
      cfg_watchdog_mode == MODE_OFF |-> ##2 !wd_reset_req && !wd_wake_req)
      else $error("mode 00 raised a request");
   AST_OST_QUIET: assert property (
      osc_startup_timer |-> ##2 !wd_reset_req && !wd_wake_req)
      else $error("request during startup timer");
   AST_KICK_FLAG: assert property (
      kick_instruction && !cif.expire |=> !timeout_flag)
      else $error("kick did not drop the time-out flag");

   // Time-out effects: flags set, sticky bits win over clears,
   // and the two requests never meet
   AST_TO_FLAG: assert property (
      cif.expire |=> timeout_flag && st_r.irq_sts[IRQ_TIMEOUT])
      else $error("time-out not recorded");
   AST_REQ_EXCL: assert property (
      wd_wake_req |-> !wd_reset_req)
      else $error("wake and reset requested together");
   AST_REQ_PULSE: assert property (
      wd_reset_req |=> !wd_reset_req)
      else $error("reset request longer than one cycle");
   AST_ENTRY_PD: assert property (
      sleep_active && !st_r.sleep_d |=> powerdown_flag)
      else $error("sleep entry not recorded");
   AST_IRQ_MATCH: assert property (
      irq == |(st_r.irq_sts & st_r.irq_en))
      else $error("interrupt level does not follow status");
endmodule

// ### tb/wdg_host_model.sv
// Purpose: Host side model: sleep control, kick, fail, start-up timer
// Assumes: One clock; start-up timer runs after every watchdog wake
// Notes: Wakes itself on a wake request and counts reset requests
`timescale 1ns/1ps
module wdg_host_model #(
   parameter int HOLD_CYC = 2000
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sleep_cmd,
   input wire logic kick_cmd,
   input wire logic fail_cmd,
   input wire logic wd_reset_req,
   input wire logic wd_wake_req,
   output logic sleep_active,
   output logic kick_instruction,
   output logic osc_fail,
   output logic osc_startup_timer,
   output int n_resets
);
   int hold_cnt; // Start-up timer cycles left
   logic cmd_d; // Sleep command, one cycle old
   // Kick and failure pass straight through
   assign kick_instruction = kick_cmd;
   assign osc_fail = fail_cmd;
   // Timer runs for crystal-style clocks after a wake
   assign osc_startup_timer = (hold_cnt != 0);
   // Sleep on a command edge only, so a wake is not undone at once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_active <= 1'b0;
         cmd_d <= 1'b0;
         hold_cnt <= 0;
         n_resets <= 0;
      end else begin
         cmd_d <= sleep_cmd;
         if (wd_wake_req || !sleep_cmd) begin
            sleep_active <= 1'b0;
         end else if (!cmd_d) begin
            sleep_active <= 1'b1;
         end
         if (wd_wake_req) begin
            hold_cnt <= HOLD_CYC;
         end else if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
         end
         if (wd_reset_req) begin
            n_resets <= n_resets + 1;
         end
      end
   end
endmodule

// ### tb/watchdog_timer_core_test.sv
// Purpose: Self-checking bench for the watchdog core over APB
// Assumes: Slow tick every 806 cycles, period code 0 is 32 ticks
// Notes: Each time-out costs about 26k cycles, so only two are run
`timescale 1ns/1ps
module watchdog_timer_core_test;
   import wdg_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic [1:0] mode = 2'h0;
   logic sleep_cmd = 1'b0, kick_cmd = 1'b0, fail_cmd = 1'b0;
   logic slp, kick, fail, hold, rreq, wreq, to_f, dn_f, rst_f, irq;
   int n_resets, el;
   int fails = 0;
   int total_checks = 0;
   // 25 MHz clock
   always #20 clk = ~clk;
   wdg_top i_wdg_top (.clk(clk), .rst_b(rst_b), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_watchdog_mode(mode), .kick_instruction(kick),
      .sleep_active(slp), .osc_fail(fail), .osc_startup_timer(hold),
      .wd_reset_req(rreq), .wd_wake_req(wreq), .timeout_flag(to_f),
      .powerdown_flag(dn_f), .wd_reset_flag(rst_f), .irq(irq));
   wdg_host_model i_wdg_host_model (.clk(clk), .rst_b(rst_b),
      .sleep_cmd(sleep_cmd), .kick_cmd(kick_cmd), .fail_cmd(fail_cmd),
      .wd_reset_req(rreq), .wd_wake_req(wreq), .sleep_active(slp),
      .kick_instruction(kick), .osc_fail(fail),
      .osc_startup_timer(hold), .n_resets(n_resets));
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; request held until pready is sampled
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Hung bus ends the run
      if (n == 16) begin
         chk("pready", 1, 0);
         tally_and_finish();
      end
   endtask
   // Bounded wait for a reset or wake pulse
   task automatic wait_req(input logic wake, input int lim);
      for (el = 0; el < lim; el++) begin
         @(posedge clk);
         if ((wake ? wreq : rreq) === 1'b1) return;
      end
      chk("request pulse", 1, 0);
      tally_and_finish();
   endtask
   task automatic kick_pulse();
      @(posedge clk);
      kick_cmd <= 1'b1;
      @(posedge clk);
      kick_cmd <= 1'b0;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      apb(0, ADDR_CTRL, 0);
      chk("ctrl reset", 32'h16, rd);
      apb(1, ADDR_CTRL, 32'hFFFFFFFF);
      apb(0, ADDR_CTRL, 0);
      chk("ctrl bits", 32'h3F, rd);
      apb(0, 8'h1C, 0);
      chk("unmapped error", 1, err);
      $display("test registers done");
      // Every mode, enable bit and sleep state
      for (int k = 0; k < 16; k++) begin
         logic [1:0] m;
         logic act;
         m = k[1:0];
         act = m == 3 || (m == 2 && !k[3]) || (m == 1 && k[2]);
         apb(1, ADDR_CTRL, {31'h0, k[2]});
         mode <= m;
         kick_pulse();
         sleep_cmd <= k[3];
         repeat (1632) @(posedge clk);
         apb(0, ADDR_COUNT, 0);
         chk("counting", act, rd != 0 && rd <= 3);
         sleep_cmd <= 1'b0;
      end
      $display("test modes done");
      mode <= 2'h3;
      fail_cmd <= 1'b1;
      repeat (1632) @(posedge clk);
      apb(0, ADDR_COUNT, 0);
      chk("count on fail", 0, rd);
      fail_cmd <= 1'b0;
      $display("test fail done");
      // Awake time-out with a reserved code, 32 ticks
      apb(1, ADDR_IRQ_EN, 7);
      apb(1, ADDR_CTRL, 32'h3E);
      kick_pulse();
      wait_req(0, 27500);
      chk("time-out delay", 1, el >= 24986 && el <= 25802);
      repeat (2) @(posedge clk);
      chk("resets", 1, n_resets);
      chk("reset flag", 1, rst_f);
      apb(0, ADDR_PWR, 0);
      chk("power status", 32'h10, rd);
      apb(0, ADDR_CTRL, 0);
      chk("ctrl reload", 32'h16, rd);
      chk("irq", 1, irq);
      apb(0, ADDR_IRQ_STS, 0);
      chk("irq status", 32'h5, rd);
      apb(1, ADDR_IRQ_EN, 0);
      repeat (2) @(posedge clk);
      chk("irq masked", 0, irq);
      apb(1, ADDR_IRQ_EN, 7);
      apb(1, ADDR_IRQ_CLR, 7);
      repeat (2) @(posedge clk);
      chk("irq cleared", 0, irq);
      apb(1, ADDR_PWR, 32'h10);
      apb(0, ADDR_PWR, 0);
      chk("power status cleared", 0, rd);
      $display("test awake time-out done");
      // Time-out in sleep wakes instead of resetting
      apb(1, ADDR_CTRL, 1);
      mode <= 2'h1;
      sleep_cmd <= 1'b1;
      wait_req(1, 27500);
      repeat (2) @(posedge clk);
      chk("no reset", 1, n_resets);
      chk("timeout flag", 1, to_f);
      chk("powerdown flag", 1, dn_f);
      apb(0, ADDR_STAT, 0);
      chk("status", 32'h7, rd);
      repeat (1000) @(posedge clk);
      apb(0, ADDR_COUNT, 0);
      chk("count in startup", 0, rd);
      kick_pulse();
      repeat (2) @(posedge clk);
      chk("flag after kick", 0, to_f);
      chk("powerdown after kick", 0, dn_f);
      repeat (2000) @(posedge clk);
      apb(0, ADDR_COUNT, 0);
      chk("count after startup", 1, rd != 0 && rd <= 3);
      sleep_cmd <= 1'b0;
      $display("test sleep time-out done");
      tally_and_finish();
   end
endmodule
